// *** rtl/wdt_timer_pkg.sv ***
// constants shared by the watchdog and basic timer block
package wdt_timer_pkg;

    // register byte addresses on the apb bus
    localparam logic [7:0] watchdog_clear_key_off = 8'hcc;
    localparam logic [7:0] basic_timer_mode_off = 8'hd8;
    localparam logic [7:0] timer_count_value_off = 8'hd9;
    localparam logic [7:0] irq_ctrl_off = 8'he0;
    localparam logic [7:0] irq_status_off = 8'he4;
    localparam logic [7:0] irq_mask_off = 8'he8;

    // reset values
    localparam logic [7:0] mode_reset = 8'h00;
    localparam logic [7:0] count_reset = 8'h00;
    localparam logic [1:0] mask_reset = 2'h0;

    // field positions
    localparam int run_bit_pos = 7;
    localparam int rate_lsb = 4;
    localparam int rate_msb = 6;
    localparam int ien_bit_pos = 0;
    localparam int flag_bit_pos = 1;
    localparam int st_ovf_pos = 0;
    localparam int st_wake_pos = 1;
    localparam int mode_used_lsb = 4;

    // watchdog and basic timer constants
    localparam logic [7:0] clear_key = 8'h5a;
    localparam int wdt_width = 13;
    localparam logic [12:0] wdt_last = 13'h1fff;
    localparam logic [7:0] count_max = 8'hff;
    localparam logic [7:0] irq_vector = 8'h08;

    // watchdog configuration option
    typedef enum logic [1:0] {
        wdt_disable = 2'h0,
        wdt_enable = 2'h1,
        wdt_always_on = 2'h2
    } wdt_option_e;

    // operating modes of the chip
    typedef enum logic [1:0] {
        mode_normal = 2'h0,
        mode_slow = 2'h1,
        mode_green = 2'h2,
        mode_power_down = 2'h3
    } op_mode_e;

endpackage : wdt_timer_pkg

// *** rtl/rate_prescaler.sv ***
// instruction clock prescaler producing one-cycle timer ticks
`timescale 1ns/1ps
`default_nettype none
module rate_prescaler
    import wdt_timer_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic run,
    input wire logic cpu_tick,
    input wire logic [2:0] rate_sel,
    output logic tick
);
    typedef struct packed {
        logic [7:0] div;
    } state_s;

    state_s st_r;
    state_s st_nxt;
    logic [7:0] last;

    always_comb begin
        st_nxt = st_r;
        last = 8'hff >> rate_sel;
        tick = 1'b0;
        if (!run) begin
            st_nxt.div = 8'h00;
        end else if (cpu_tick) begin
            if ((st_r.div & last) == last) begin
                tick = 1'b1;
                st_nxt.div = 8'h00;
            end else begin
                st_nxt.div = st_r.div + 8'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule : rate_prescaler
`default_nettype wire

// *** rtl/watchdog_counter.sv ***
// watchdog counter on the low-speed oscillator ticks
`timescale 1ns/1ps
`default_nettype none
module watchdog_counter
    import wdt_timer_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [1:0] wdt_option,
    input wire logic [1:0] op_mode,
    input wire logic lso_tick,
    input wire logic clear,
    output logic overflow
);
    typedef struct packed {
        logic [12:0] cnt;
    } state_s;

    state_s st_r;
    state_s st_nxt;
    logic active;

    always_comb begin
        st_nxt = st_r;
        overflow = 1'b0;
        active = 1'b0;
        unique case (wdt_option)
            wdt_enable: active = (op_mode == mode_normal) || (op_mode == mode_slow);
            wdt_always_on: active = 1'b1;
            default: active = 1'b0;
        endcase
        if (clear || !active && wdt_option == wdt_disable) begin
            st_nxt.cnt = '0;
        end else if (active && lso_tick) begin
            st_nxt.cnt = st_r.cnt + 13'h0001;
            overflow = (st_r.cnt == wdt_last);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule : watchdog_counter
`default_nettype wire

// *** rtl/watchdog_and_basic_timer.sv ***
// watchdog and 8-bit basic up timer with apb registers
// How it works
// - the watchdog is a binary up counter whose overflow resets the whole chip.
// - the watchdog counts low-speed oscillator ticks and overflows after 8192 of them.
// - with the enable option it counts in normal and slow modes only, disabled it does nothing.
// - with the always-on option it also counts in power-down and clocked sleep.
// - writing 0x5a to the write-only clear key restarts the watchdog count.
// - the basic timer is an 8-bit up counter that keeps counting past its wrap and flags it.
// - it counts the instruction clock divided by 256 (code 000) down to 2 (code 111).
// - it counts only while the run bit, mode bit 7, is set.
// - each wrap from 0xff to 0x00 sets the timer request flag.
// - the flag sets regardless of the interrupt enable; only the enable vectors the cpu.
// - with the enable set an overflow redirects the program counter to vector 8.
// - with the run bit set the timer keeps counting in clocked sleep.
// - an overflow in clocked sleep wakes the chip to its previous mode.
// - there is no auto-reload; counting resumes from zero for 256 counts.
// - the count is an 8-bit read/write register reset to zero.
`timescale 1ns/1ps
`default_nettype none
module watchdog_and_basic_timer
    import wdt_timer_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] wdt_option,
    input wire logic [1:0] op_mode,
    input wire logic [1:0] sleep_from_mode,
    input wire logic lso_tick,
    input wire logic cpu_tick,
    output logic chip_reset,
    output logic vector_req,
    output logic [7:0] vector_addr,
    output logic wake_req,
    output logic [1:0] wake_mode,
    output logic irq
);
    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] count;
        logic ien;
        logic flag;
        logic [1:0] status;
        logic [1:0] mask;
        logic [31:0] rdata;
        logic ready;
        logic err;
        logic chip_reset;
        logic vector_req;
        logic wake_req;
        logic [1:0] wake_mode;
        logic irq;
    } state_s;

    state_s st_r;
    state_s st_nxt;
    logic tick;
    logic wdt_ovf;
    logic wdt_clear;
    logic access;
    logic wr;
    logic rd;
    logic wrap;
    logic [1:0] ev;
    logic mapped;

    ////////////////////////////////////////////////////////////////////////////////////
    // submodules

    rate_prescaler u_pre (
        .clk(clk),
        .srst(srst),
        .run(st_r.mode[run_bit_pos]),
        .cpu_tick(cpu_tick),
        .rate_sel(st_r.mode[rate_msb:rate_lsb]),
        .tick(tick)
    );

    watchdog_counter u_wdt (
        .clk(clk),
        .srst(srst),
        .wdt_option(wdt_option),
        .op_mode(op_mode),
        .lso_tick(lso_tick),
        .clear(wdt_clear),
        .overflow(wdt_ovf)
    );

    ////////////////////////////////////////////////////////////////////////////////////
    // bus decode

    always_comb begin
        access = psel && penable && !st_r.ready;
        wr = access && pwrite;
        rd = access && !pwrite;
        mapped = (paddr == watchdog_clear_key_off) || (paddr == basic_timer_mode_off) ||
                 (paddr == timer_count_value_off) || (paddr == irq_ctrl_off) ||
                 (paddr == irq_status_off) || (paddr == irq_mask_off);
        wdt_clear = wr && paddr == watchdog_clear_key_off && pwdata[7:0] == clear_key;
        wrap = tick && st_r.count == count_max;
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        st_nxt = st_r;
        st_nxt.ready = access;
        st_nxt.err = access && !mapped;
        st_nxt.rdata = '0;
        st_nxt.vector_req = 1'b0;
        st_nxt.wake_req = 1'b0;
        st_nxt.chip_reset = wdt_ovf;
        // counter runs in every mode while enabled, sleep included
        if (tick) begin
            st_nxt.count = st_r.count + 8'h01;
        end
        if (wrap) begin
            st_nxt.flag = 1'b1;
            st_nxt.vector_req = st_r.ien;
            if (op_mode == mode_green) begin
                st_nxt.wake_req = 1'b1;
                st_nxt.wake_mode = sleep_from_mode;
            end
        end
        if (wr) begin
            unique case (paddr)
                basic_timer_mode_off: st_nxt.mode = {pwdata[7:mode_used_lsb], 4'h0};
                timer_count_value_off: st_nxt.count = pwdata[7:0];
                irq_ctrl_off: begin
                    st_nxt.ien = pwdata[ien_bit_pos];
                    if (!pwdata[flag_bit_pos] && !wrap) begin
                        st_nxt.flag = 1'b0;
                    end
                end
                irq_mask_off: st_nxt.mask = pwdata[1:0];
                default: ;
            endcase
        end
        if (rd) begin
            unique case (paddr)
                basic_timer_mode_off: st_nxt.rdata = {24'h0, st_r.mode};
                timer_count_value_off: st_nxt.rdata = {24'h0, st_r.count};
                irq_ctrl_off: st_nxt.rdata = {30'h0, st_r.flag, st_r.ien};
                irq_status_off: begin
                    st_nxt.rdata = {30'h0, st_r.status};
                    st_nxt.status = 2'h0;
                end
                irq_mask_off: st_nxt.rdata = {30'h0, st_r.mask};
                default: st_nxt.rdata = '0;
            endcase
        end
        ev = 2'h0;
        ev[st_ovf_pos] = wrap;
        ev[st_wake_pos] = wrap && op_mode == mode_green;
        st_nxt.status = st_nxt.status | ev;
        st_nxt.irq = |(st_nxt.status & st_nxt.mask);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_r <= '0;
            st_r.mode <= mode_reset;
            st_r.count <= count_reset;
            st_r.mask <= mask_reset;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // outputs

    always_comb begin
        prdata = st_r.rdata;
        pready = st_r.ready;
        pslverr = st_r.err;
        chip_reset = st_r.chip_reset;
        vector_req = st_r.vector_req;
        vector_addr = irq_vector;
        wake_req = st_r.wake_req;
        wake_mode = st_r.wake_mode;
        irq = st_r.irq;
    end
endmodule : watchdog_and_basic_timer
`default_nettype wire

// *** bench/wdt_timer_props.sv ***
// port assertions for the watchdog and basic timer
`timescale 1ns/1ps
`default_nettype none
module wdt_timer_props
    import wdt_timer_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [1:0] wdt_option,
    input wire logic [1:0] op_mode,
    input wire logic [1:0] sleep_from_mode,
    input wire logic chip_reset,
    input wire logic vector_req,
    input wire logic [7:0] vector_addr,
    input wire logic wake_req,
    input wire logic [1:0] wake_mode
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    sequence acc_s;
        psel && penable && !pready;
    endsequence
    pready_wait_a: assert property (acc_s |=> pready) else $error("no answer");
    err_pair_a: assert property (pslverr |-> pready) else $error("lone error");
    key_read_a: assert property (pready && !pwrite && paddr == watchdog_clear_key_off
        |-> prdata == 32'h0) else $error("key readable");
    rst_pulse_a: assert property (chip_reset |=> !chip_reset) else $error("long reset");
    wdt_off_a: assert property ($past(wdt_option) == wdt_disable |-> !chip_reset)
        else $error("disabled reset");
    vec_addr_a: assert property (vector_req |-> vector_addr == irq_vector)
        else $error("bad vector");
    vec_pulse_a: assert property (vector_req |=> !vector_req) else $error("long vector");
    wake_src_a: assert property (wake_req |-> $past(op_mode) == mode_green
        && wake_mode == $past(sleep_from_mode)) else $error("bad wake");
endmodule : wdt_timer_props
bind watchdog_and_basic_timer wdt_timer_props i_props(.clk(clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wdt_option(wdt_option), .op_mode(op_mode),
    .sleep_from_mode(sleep_from_mode), .chip_reset(chip_reset), .vector_req(vector_req),
    .vector_addr(vector_addr), .wake_req(wake_req), .wake_mode(wake_mode));
`default_nettype wire

// *** bench/tb_top.sv ***
// self-checking bench for the watchdog and basic timer
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import wdt_timer_pkg::*;
;
    localparam logic [7:0] cnt_a = timer_count_value_off;
    localparam logic [7:0] mod_a = basic_timer_mode_off;
    logic clk = 1'h0, srst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic lso_tick = 1'h0, cpu_tick = 1'h1, pready, pslverr, chip_reset, vector_req;
    logic wake_req, irq;
    logic [7:0] paddr = 8'h0, vector_addr;
    logic [31:0] pwdata = 32'h0, prdata, rdata, v;
    logic [1:0] wdt_option = 2'h0, op_mode = 2'h0, sleep_from_mode = 2'h1, wake_mode;
    logic [1:0] opt[4] = '{2'h1, 2'h1, 2'h2, 2'h0};
    logic [1:0] md[4] = '{2'h0, 2'h3, 2'h2, 2'h0};
    logic [32:0] exp_q[$], msk_q[$], m;
    int fail_count = 0, num_checks = 0, cyc = 0, ticks = 0, vec_n = 0, t0, i;
    watchdog_and_basic_timer i_dut(.clk(clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .wdt_option(wdt_option), .op_mode(op_mode),
        .sleep_from_mode(sleep_from_mode), .lso_tick(lso_tick), .cpu_tick(cpu_tick),
        .chip_reset(chip_reset), .vector_req(vector_req), .vector_addr(vector_addr),
        .wake_req(wake_req), .wake_mode(wake_mode), .irq(irq));
    always #12.5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string n, input logic [32:0] s, input logic [32:0] e);
        num_checks++;
        if (s !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask : check
    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : conclude
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        input logic [32:0] e, input logic [32:0] k);
        exp_q.push_back(e);
        msk_q.push_back(k);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk) penable <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1);
        rdata = prdata;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'h1, a, d, 33'h0, 33'h100000000);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] k);
        xfer(1'h0, a, 32'h0, {1'h0, e}, {1'h1, k});
    endtask : rd
    ////////////////////////////////////////////////////////////////////////////
    // scoreboard, tick source and timeout
    always @(posedge clk) begin
        cyc++;
        if (lso_tick) ticks++;
        if (vector_req) vec_n++;
        lso_tick <= ($urandom % 4) != 0;
        if (psel && penable && pready) begin
            m = msk_q.pop_front();
            check("apb", {pslverr, prdata} & m, exp_q.pop_front() & m);
        end
        if (cyc == 100000) begin
            fail_count++;
            conclude();
        end
    end
    initial begin
        void'($urandom(75193));
        repeat (4) @(posedge clk);
        srst <= 1'h0;
        @(posedge clk);
        rd(mod_a, mode_reset, 32'hffffffff);
        rd(cnt_a, count_reset, 32'hffffffff);
        rd(watchdog_clear_key_off, 32'h0, 32'hffffffff);
        rd(irq_mask_off, 32'h0, 32'hffffffff);
        xfer(1'h0, 8'hf0, 32'h0, 33'h100000000, 33'h1ffffffff);
        v = $urandom;
        wr(mod_a, v & 32'h7f);
        rd(mod_a, v & 32'h70, 32'hffffffff);
        wr(cnt_a, v[15:8]);
        rd(cnt_a, v[15:8], 32'hffffffff);
        xfer(1'h1, 8'hf4, v, 33'h100000000, 33'h100000000);
        $display("test registers done");
        for (i = 0; i < 8; i++) begin
            wr(cnt_a, 32'h10);
            wr(mod_a, {24'h0, 1'h1, i[2:0], 4'h0});
            repeat ((2048 >> i) - 4) @(posedge clk);
            wr(mod_a, {24'h0, 1'h0, i[2:0], 4'h0});
            rd(cnt_a, 32'h0, 32'h0);
            check("rate", rdata[7:0] >= 8'h17 && rdata[7:0] <= 8'h19, 33'h1);
        end
        repeat (20) @(posedge clk);
        rd(cnt_a, rdata, 32'hffffffff);
        $display("test rates done");
        wr(irq_mask_off, 32'h1);
        wr(irq_ctrl_off, 32'h0);
        vec_n = 0;
        wr(cnt_a, 32'hfe);
        wr(mod_a, 32'hf0);
        for (i = 0; i < 50 && irq !== 1'h1; i++) @(posedge clk);
        check("irq", irq, 33'h1);
        check("vector", vec_n, 33'h0);
        rd(irq_ctrl_off, 32'h2, 32'h3);
        rd(irq_status_off, 32'h1, 32'h1);
        rd(irq_status_off, 32'h0, 32'h1);
        @(posedge clk);
        check("irq", irq, 33'h0);
        wr(irq_ctrl_off, 32'h1);
        rd(irq_ctrl_off, 32'h1, 32'h3);
        for (i = 0; i < 700 && vector_req !== 1'h1; i++) @(posedge clk);
        check("vector", vector_req, 33'h1);
        check("addr", vector_addr, irq_vector);
        check("wrap", i > 400, 33'h1);
        $display("test interrupt done");
        op_mode <= mode_green;
        wr(cnt_a, 32'hf0);
        for (i = 0; i < 60 && wake_req !== 1'h1; i++) @(posedge clk);
        check("wake", wake_req, 33'h1);
        check("wake_mode", wake_mode, mode_slow);
        rd(irq_status_off, 32'h2, 32'h2);
        op_mode <= mode_normal;
        wr(mod_a, 32'h0);
        $display("test wake done");
        for (i = 0; i < 4; i++) begin
            wdt_option <= opt[i];
            op_mode <= md[i];
            repeat (3000) @(posedge clk);
            wr(watchdog_clear_key_off, {24'h0, clear_key});
            t0 = ticks;
            while (chip_reset !== 1'h1 && ticks - t0 < 8300) @(posedge clk);
            check("wdt", chip_reset, i[0] ? 33'h0 : 33'h1);
            if (!i[0]) check("wdt_n", ticks - t0 >= 8185 && ticks - t0 <= 8195, 33'h1);
        end
        $display("test watchdog done");
        conclude();
    end
endmodule : tb_top
`default_nettype wire
